// *** hw/timer_capture_pwm.sv ***
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module timer_capture_pwm
    import timer_capture_pwm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic external_count_clock_pin_in,
    input wire logic [1:0] channel_pin_in,
    output logic [1:0] channel_pin_out,
    output logic [1:0] channel_pin_oe_out,
    output logic wrap_irq_out,
    output logic [1:0] channel_irq_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic halt_ff;
    logic wrap_flag_ff;
    logic wrap_arm_ff;
    logic wrap_ie_ff;
    logic [2:0] ps_ff;
    logic [PRESC_W-1:0] presc_ff;
    logic [15:0] cnt_ff;
    logic [7:0] low_latch_ff;
    logic latched_ff;
    logic [15:0] period_ff;
    logic period_inhibit_ff;
    logic buf_ff;
    logic act_sel_ff;
    logic pend_ff;
    logic [1:0][15:0] val_ff;
    logic [1:0] capblk_ff;
    logic [1:0] cmpblk_ff;
    logic [1:0] flag_ff;
    logic [1:0] arm_ff;
    logic [1:0] ie_ff;
    logic [1:0] mode_a_ff;
    logic [1:0][1:0] els_ff;
    logic [1:0] tov_ff;
    logic [1:0] max_ff;
    logic [1:0] max_eff_ff;
    logic [1:0] out_ff;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    logic [1:0] pin_meta_ff;
    logic [1:0] pin_sync_ff;
    logic [1:0] pin_prev_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    // ------------------------------------------------------------
    // decode and counting strobes
    // ------------------------------------------------------------
    logic wr_tc;
    logic rd_tc;
    logic cnt_clear;
    logic presc_tick;
    logic src_tick;
    logic adv;
    logic at_period;
    logic wrap_evt;
    logic [15:0] nxt_cnt;
    logic [PRESC_W-1:0] presc_mask;

    assign wr_tc = reg_wr_in && (reg_addr_in == ADDR_TIMER_CTRL);
    assign rd_tc = reg_rd_in && (reg_addr_in == ADDR_TIMER_CTRL);
    assign cnt_clear = wr_tc && reg_wdata_in[TC_RESET];
    // divide by 2^n: tick when the low n prescaler bits are all ones
    assign presc_mask = ~({PRESC_W{1'b1}} << ps_ff);
    assign presc_tick = ((presc_ff & presc_mask) == presc_mask);
    assign src_tick = (ps_ff == PS_EXT_PIN) ? (ext_sync_ff && !ext_prev_ff) : presc_tick;
    assign adv = src_tick && !halt_ff && !cnt_clear;
    assign at_period = (cnt_ff == period_ff);
    assign wrap_evt = adv && at_period;
    assign nxt_cnt = at_period ? 16'h0000 : cnt_ff + 16'h0001;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two stages before any logic, third stage for edge detect
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
            pin_meta_ff <= 2'h0;
            pin_sync_ff <= 2'h0;
            pin_prev_ff <= 2'h0;
        end else begin
            ext_meta_ff <= external_count_clock_pin_in;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
            pin_meta_ff <= channel_pin_in;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // ------------------------------------------------------------
    // timer control register
    // ------------------------------------------------------------
    // halt, enable and clock select; reset bit is a pulse only
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            halt_ff <= 1'b1;
            wrap_ie_ff <= 1'b0;
            ps_ff <= PS_RESET;
        end else if (wr_tc) begin
            halt_ff <= reg_wdata_in[TC_HALT];
            wrap_ie_ff <= reg_wdata_in[TC_WRAP_IE];
            ps_ff <= reg_wdata_in[TC_PS_LSB +: PS_W];
        end
    end

    // wrap flag: set wins, clear needs a prior read with flag set
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wrap_flag_ff <= 1'b0;
            wrap_arm_ff <= 1'b0;
        end else if (wrap_evt && !period_inhibit_ff) begin
            wrap_flag_ff <= 1'b1;
            wrap_arm_ff <= 1'b0;
        end else if (wr_tc) begin
            if (!reg_wdata_in[TC_WRAP_FLAG] && wrap_arm_ff) begin
                wrap_flag_ff <= 1'b0;
            end
            wrap_arm_ff <= 1'b0;
        end else if (rd_tc && wrap_flag_ff) begin
            wrap_arm_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_ff <= '0;
        end else if (cnt_clear) begin
            presc_ff <= '0;
        end else if (!halt_ff) begin
            presc_ff <= presc_ff + 1'b1;
        end
    end

    // a clear overrides counting; with halt set it parks at zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= 16'h0000;
        end else if (cnt_clear) begin
            cnt_ff <= 16'h0000;
        end else if (adv) begin
            cnt_ff <= nxt_cnt;
        end
    end

    // low byte snapshot taken by a high byte read
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_latch_ff <= 8'h00;
            latched_ff <= 1'b0;
        end else if (cnt_clear) begin
            low_latch_ff <= 8'h00;
            latched_ff <= 1'b0;
        end else if (reg_rd_in && reg_addr_in == ADDR_COUNT_HIGH && !latched_ff) begin
            low_latch_ff <= cnt_ff[7:0];
            latched_ff <= 1'b1;
        end else if (reg_rd_in && reg_addr_in == ADDR_COUNT_LOW) begin
            latched_ff <= 1'b0;
        end
    end

    // period register; high write suppresses wrap flag until low write
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            period_ff <= PERIOD_RESET;
            period_inhibit_ff <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == ADDR_PERIOD_HIGH) begin
            period_ff[15:8] <= reg_wdata_in;
            period_inhibit_ff <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == ADDR_PERIOD_LOW) begin
            period_ff[7:0] <= reg_wdata_in;
            period_inhibit_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // buffered linking of the two channels
    // ------------------------------------------------------------
    // buffered bit lives in channel 0 control only
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buf_ff <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == ADDR_CH_CTRL[0]) begin
            buf_ff <= reg_wdata_in[CC_BUF];
        end
    end

    // writing the idle register's low byte queues a swap at wrap
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            act_sel_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else if (!buf_ff) begin
            act_sel_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else if (wrap_evt && pend_ff) begin
            act_sel_ff <= !act_sel_ff;
            pend_ff <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == ADDR_CH_LOW[!act_sel_ff]) begin
            pend_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic disabled;
        logic is_capture;
        logic is_compare;
        logic sel_ch;
        logic [15:0] cmp_val;
        logic cmp_blk;
        logic match;
        logic cap;
        logic evt;
        logic wr_ctrl;
        logic rd_ctrl;
        logic force_full;
        logic [1:0] els;

        assign els = els_ff[c];
        // channel 1 control is switched off while linked
        assign disabled = (c == 1) && buf_ff;
        assign wr_ctrl = reg_wr_in && reg_addr_in == ADDR_CH_CTRL[c] && !disabled;
        assign rd_ctrl = reg_rd_in && reg_addr_in == ADDR_CH_CTRL[c];
        assign is_capture = !disabled && els != ELS_PORT && !mode_a_ff[c]
                            && !((c == 0) && buf_ff);
        assign is_compare = !disabled && els != ELS_PORT && !is_capture;
        // linked channel 0 compares against the active buffer
        assign sel_ch = ((c == 0) && buf_ff) ? act_sel_ff : 1'(c);
        assign cmp_val = val_ff[sel_ch];
        assign cmp_blk = cmpblk_ff[sel_ch];
        assign match = is_compare && adv && nxt_cnt == cmp_val && !cmp_blk;
        assign cap = is_capture && ((els[0] && pin_sync_ff[c] && !pin_prev_ff[c])
                     || (els[1] && !pin_sync_ff[c] && pin_prev_ff[c]));
        assign evt = match || cap;
        assign force_full = !tov_ff[c] && max_eff_ff[c];

        // control register fields
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                ie_ff[c] <= 1'b0;
                mode_a_ff[c] <= 1'b0;
                els_ff[c] <= ELS_PORT;
                tov_ff[c] <= 1'b0;
                max_ff[c] <= 1'b0;
            end else if (wr_ctrl) begin
                ie_ff[c] <= reg_wdata_in[CC_IE];
                mode_a_ff[c] <= reg_wdata_in[CC_MODE_A];
                els_ff[c] <= reg_wdata_in[CC_ELS_LSB +: 2];
                tov_ff[c] <= reg_wdata_in[CC_TOV];
                max_ff[c] <= reg_wdata_in[CC_MAX];
            end
        end

        // event flag: set wins over a clear in the same cycle
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                flag_ff[c] <= 1'b0;
                arm_ff[c] <= 1'b0;
            end else if (evt) begin
                flag_ff[c] <= 1'b1;
                arm_ff[c] <= 1'b0;
            end else if (wr_ctrl) begin
                if (!reg_wdata_in[CC_FLAG] && arm_ff[c]) begin
                    flag_ff[c] <= 1'b0;
                end
                arm_ff[c] <= 1'b0;
            end else if (rd_ctrl && flag_ff[c] && !disabled) begin
                arm_ff[c] <= 1'b1;
            end
        end

        // value register with capture and compare blocking
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                capblk_ff[c] <= 1'b0;
                cmpblk_ff[c] <= 1'b0;
            end else if (reg_rd_in && reg_addr_in == ADDR_CH_HIGH[c] && is_capture) begin
                capblk_ff[c] <= 1'b1;
            end else if (reg_rd_in && reg_addr_in == ADDR_CH_LOW[c]) begin
                capblk_ff[c] <= 1'b0;
            end else if (reg_wr_in && reg_addr_in == ADDR_CH_HIGH[c] && !is_capture) begin
                cmpblk_ff[c] <= 1'b1;
            end else if (reg_wr_in && reg_addr_in == ADDR_CH_LOW[c]) begin
                cmpblk_ff[c] <= 1'b0;
            end
        end

        // contents undefined after reset, so no reset branch
        always_ff @(posedge clk_sys_in) begin
            if (cap && !capblk_ff[c]) begin
                val_ff[c] <= cnt_ff;
            end else if (reg_wr_in && reg_addr_in == ADDR_CH_HIGH[c]) begin
                val_ff[c][15:8] <= reg_wdata_in;
            end else if (reg_wr_in && reg_addr_in == ADDR_CH_LOW[c]) begin
                val_ff[c][7:0] <= reg_wdata_in;
            end
        end

        // full duty takes hold at the next pwm cycle boundary
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                max_eff_ff[c] <= 1'b0;
            end else if (wrap_evt || !is_compare) begin
                max_eff_ff[c] <= max_ff[c];
            end
        end

        // output level: preset, forced, wrap toggle, then match action
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                out_ff[c] <= 1'b1;
            end else if (els == ELS_PORT) begin
                out_ff[c] <= !mode_a_ff[c];
            end else if (!is_compare) begin
                out_ff[c] <= out_ff[c];
            end else if (force_full) begin
                out_ff[c] <= (els != ELS_SET);
            end else if (wrap_evt && tov_ff[c]) begin
                out_ff[c] <= !out_ff[c];
            end else if (match) begin
                case (els)
                    ELS_TOGGLE: out_ff[c] <= !out_ff[c];
                    ELS_CLEAR: out_ff[c] <= 1'b0;
                    ELS_SET: out_ff[c] <= 1'b1;
                    default: out_ff[c] <= out_ff[c];
                endcase
            end
        end

        assign channel_pin_out[c] = out_ff[c];
        assign channel_pin_oe_out[c] = is_compare;
        assign channel_irq_out[c] = flag_ff[c] && ie_ff[c];
    end

    assign wrap_irq_out = wrap_flag_ff && wrap_ie_ff;

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_addr_in)
            ADDR_TIMER_CTRL: begin
                nxt_rdata[TC_WRAP_FLAG] = wrap_flag_ff;
                nxt_rdata[TC_WRAP_IE] = wrap_ie_ff;
                nxt_rdata[TC_HALT] = halt_ff;
                nxt_rdata[TC_PS_LSB +: PS_W] = ps_ff;             // reset bit reads zero
            end
            ADDR_COUNT_HIGH: nxt_rdata = cnt_ff[15:8];
            ADDR_COUNT_LOW: nxt_rdata = latched_ff ? low_latch_ff : cnt_ff[7:0];
            ADDR_PERIOD_HIGH: nxt_rdata = period_ff[15:8];
            ADDR_PERIOD_LOW: nxt_rdata = period_ff[7:0];
            ADDR_CH_CTRL[0]: nxt_rdata = {flag_ff[0], ie_ff[0], buf_ff, mode_a_ff[0],
                                          els_ff[0], tov_ff[0], max_ff[0]};
            ADDR_CH_CTRL[1]: nxt_rdata = {flag_ff[1], ie_ff[1], 1'b0, mode_a_ff[1],
                                          els_ff[1], tov_ff[1], max_ff[1]};
            ADDR_CH_HIGH[0]: nxt_rdata = val_ff[0][15:8];
            ADDR_CH_LOW[0]: nxt_rdata = val_ff[0][7:0];
            ADDR_CH_HIGH[1]: nxt_rdata = val_ff[1][15:8];
            ADDR_CH_LOW[1]: nxt_rdata = val_ff[1][7:0];
            default: nxt_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_in) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata_out = rdata_ff;
endmodule : timer_capture_pwm

// *** inc/timer_capture_pwm_pkg.sv ***
// What this block does
// - counter reset bit clears counter, latch, prescaler
// - halt plus reset holds counter at zero
// - clock select divides bus clock or picks pin
// - high byte read latches low byte until read
// - match on period sets wrap flag, restarts
// - period high write suppresses wrap flag until low
// - channel flag on capture edge or compare match
// - channel flag clears by read then zero write
// - channel irq enable gates channel request
// - channel 0 buffered bit links both channels
// - edge level zero gives port control, preset
// - capture edges: rising, falling or either
// - unbuffered compare toggles, clears or sets pin
// - buffered compare toggles, clears or sets pin
// - toggle on wrap flips compare pin at overflow
// - wrap action beats same count compare match
// - full duty bit forces 100 percent next cycle if toggle on wrap is off
// - capture high read blocks captures until low
// - compare high write blocks matches until low
// - channel value holds capture or compare value
// - halt bit stops counting, set by reset
// - wrap flag clears by read then zero write
package timer_capture_pwm_pkg;
    // ------------------------------------------------------------
    // register map (byte registers)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_TIMER_CTRL = 4'h0;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
    localparam logic [3:0] ADDR_PERIOD_HIGH = 4'h3;
    localparam logic [3:0] ADDR_PERIOD_LOW = 4'h4;
    localparam logic [3:0] ADDR_CH_CTRL [2] = '{4'h5, 4'h8};
    localparam logic [3:0] ADDR_CH_HIGH [2] = '{4'h6, 4'h9};
    localparam logic [3:0] ADDR_CH_LOW [2] = '{4'h7, 4'hA};
    // ------------------------------------------------------------
    // timer control/status fields
    // ------------------------------------------------------------
    localparam int TC_WRAP_FLAG = 7;
    localparam int TC_WRAP_IE = 6;
    localparam int TC_HALT = 5;
    localparam int TC_RESET = 4;
    localparam int TC_PS_LSB = 0;
    localparam int PS_W = 3;
    localparam logic [2:0] PS_EXT_PIN = 3'h7;
    localparam logic [2:0] PS_RESET = 3'h0;
    localparam int PRESC_W = 6;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    // ------------------------------------------------------------
    // channel control/status fields
    // ------------------------------------------------------------
    localparam int CC_FLAG = 7;
    localparam int CC_IE = 6;
    localparam int CC_BUF = 5;
    localparam int CC_MODE_A = 4;
    localparam int CC_ELS_LSB = 2;
    localparam int CC_TOV = 1;
    localparam int CC_MAX = 0;
    localparam logic [1:0] ELS_PORT = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
endpackage : timer_capture_pwm_pkg

// *** sim/timer_capture_pwm_asserts.sv ***
`timescale 1ns/1ps
module timer_capture_pwm_asserts
    import timer_capture_pwm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [1:0] channel_pin_out,
    input wire logic [1:0] channel_pin_oe_out,
    input wire logic wrap_irq_out,
    input wire logic [1:0] channel_irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic ch0_wr;
    logic tc_wr;
    // write strobes of the timer control and channel 0 control registers
    assign ch0_wr = reg_wr_in && reg_addr_in == ADDR_CH_CTRL[0];
    assign tc_wr = reg_wr_in && reg_addr_in == ADDR_TIMER_CTRL;
    property p_rst_bit; reg_rd_in && reg_addr_in == ADDR_TIMER_CTRL |=> !reg_rdata_out[TC_RESET]; endproperty
    a_rst_bit: assert property (p_rst_bit) else $error("counter reset bit read as one");
    property p_ch1_buf; reg_rd_in && reg_addr_in == ADDR_CH_CTRL[1] |=> !reg_rdata_out[CC_BUF]; endproperty
    a_ch1_buf: assert property (p_ch1_buf) else $error("channel 1 shows buffered bit");
    property p_buf_pin; ch0_wr && reg_wdata_in[CC_BUF] |=> !channel_pin_oe_out[1]; endproperty
    a_buf_pin: assert property (p_buf_pin) else $error("channel 1 pin driven in buffered mode");
    property p_ie_gate; ch0_wr && !reg_wdata_in[CC_IE] |=> !channel_irq_out[0]; endproperty
    a_ie_gate: assert property (p_ie_gate) else $error("channel request without enable");
    property p_ch_one; ch0_wr && channel_irq_out[0] && reg_wdata_in[CC_FLAG] && reg_wdata_in[CC_IE]
        |=> channel_irq_out[0]; endproperty
    a_ch_one: assert property (p_ch_one) else $error("writing one cleared channel flag");
    property p_wrap_one; tc_wr && wrap_irq_out && reg_wdata_in[TC_WRAP_FLAG] && reg_wdata_in[TC_WRAP_IE]
        |=> wrap_irq_out; endproperty
    a_wrap_one: assert property (p_wrap_one) else $error("writing one cleared wrap flag");
    property p_port_oe; ch0_wr && reg_wdata_in[CC_ELS_LSB+:2] == ELS_PORT |=> !channel_pin_oe_out[0]; endproperty
    a_port_oe: assert property (p_port_oe) else $error("pin driven under port control");
    property p_preset; ch0_wr && reg_wdata_in[CC_ELS_LSB+:2] == ELS_PORT ##1 !reg_wr_in
        |=> channel_pin_out[0] == !$past(reg_wdata_in[CC_MODE_A], 2); endproperty
    a_preset: assert property (p_preset) else $error("preset level wrong");
endmodule : timer_capture_pwm_asserts

// *** sim/pin_partner.sv ***
`timescale 1ns/1ps
module pin_partner (
    input wire logic clk_sys_in,
    input wire logic [1:0] level_in,
    input wire logic ext_run_in,
    output logic [1:0] pin_out = 2'h0,
    output logic ext_clk_out = 1'b0
);
    logic [1:0] div_ff = 2'h0;
    // pin levels change only on clock edges and are held for many clocks
    always @(posedge clk_sys_in) pin_out <= level_in;
    // count clock at a quarter of the bus rate, standing low while idle
    always @(posedge clk_sys_in) begin
        div_ff <= ext_run_in ? div_ff + 2'h1 : 2'h0;
        ext_clk_out <= ext_run_in && div_ff[1];
    end
endmodule : pin_partner

// *** sim/test_timer_capture_pwm.sv ***
`timescale 1ns/1ps
module test_timer_capture_pwm
    import timer_capture_pwm_pkg::*;
;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, ext_run = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, d;
    logic [1:0] level = 2'h0, far_pin, pin_out, pin_oe, ch_irq, pin_in;
    logic wrap_irq, ext_clk;
    int n_fail = 0, tests_run = 0, cycles = 0;
    // wire level of each channel pin
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & far_pin);
    timer_capture_pwm DUT (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .external_count_clock_pin_in(ext_clk), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
        .channel_pin_oe_out(pin_oe), .wrap_irq_out(wrap_irq), .channel_irq_out(ch_irq));
    pin_partner far (.clk_sys_in, .level_in(level), .ext_run_in(ext_run), .pin_out(far_pin), .ext_clk_out(ext_clk));
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    // hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            results();
        end
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : rd
    task automatic rdc(input logic [3:0] a, input logic [7:0] x);
        rd(a, d);
        chk(d, x);
    endtask : rdc
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : wait_clk
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_count();
        logic [15:0] c;
        rdc(ADDR_TIMER_CTRL, 8'h20);
        rdc(ADDR_PERIOD_LOW, 8'hFF);
        wr(4'hF, 8'h55);
        rdc(4'hF, 8'h00);
        for (int ps = 0; ps < 8; ps++) begin
            ext_run <= (ps == 7);
            wr(ADDR_TIMER_CTRL, 8'h10 | 8'(ps));
            wait_clk(128);
            wr(ADDR_TIMER_CTRL, 8'h20 | 8'(ps));
            rd(ADDR_COUNT_HIGH, c[15:8]);
            rd(ADDR_COUNT_LOW, c[7:0]);
            chk(c >= (128 >> (ps % 7 + ps / 7 * 2)) - 2 && c <= (132 >> (ps % 7 + ps / 7 * 2)) + 1, 1'b1);
        end
        ext_run <= 1'b0;
        wr(ADDR_TIMER_CTRL, 8'h30);
        rd(ADDR_COUNT_HIGH, c[15:8]);
        rd(ADDR_COUNT_LOW, c[7:0]);
        chk(c, 16'h0000);
        wr(ADDR_TIMER_CTRL, 8'h10);
        rd(ADDR_COUNT_HIGH, c[15:8]);
        wait_clk(300);
        rd(ADDR_COUNT_LOW, c[7:0]);
        rd(ADDR_COUNT_HIGH, c[15:8]);
        rd(ADDR_COUNT_LOW, d);
        d = d - c[7:0];
        chk(d >= 8'd45 && d <= 8'd51, 1'b1);
    endtask : s_count
    task automatic s_wrap();
        wr(ADDR_TIMER_CTRL, 8'h30);
        wr(ADDR_PERIOD_HIGH, 8'h00);
        wr(ADDR_PERIOD_LOW, 8'h07);
        wr(ADDR_PERIOD_HIGH, 8'h00);
        wr(ADDR_TIMER_CTRL, 8'h50);
        wait_clk(40);
        chk(wrap_irq, 1'b0);
        wr(ADDR_PERIOD_LOW, 8'h07);
        wait_clk(12);
        chk(wrap_irq, 1'b1);
        wr(ADDR_TIMER_CTRL, 8'hE0);
        rdc(ADDR_TIMER_CTRL, 8'hE0);
        wr(ADDR_TIMER_CTRL, 8'h70);
        chk(wrap_irq, 1'b0);
        rdc(ADDR_PERIOD_LOW, 8'h07);
    endtask : s_wrap
    task automatic s_capture();
        for (int k = 1; k < 4; k++) begin
            wr(ADDR_CH_CTRL[0], 8'h40 | 8'(k << 2));
            level[0] <= 1'b1;
            wait_clk(8);
            chk(ch_irq[0], k[0]);
            wr(ADDR_CH_CTRL[0], 8'hC0 | 8'(k << 2));
            rdc(ADDR_CH_HIGH[0], 8'h00);
            rdc(ADDR_CH_LOW[0], 8'h00);
            rdc(ADDR_CH_CTRL[0], 8'(k[0] * 128 + 64 + k * 4));
            wr(ADDR_CH_CTRL[0], 8'h40 | 8'(k << 2));
            chk(ch_irq[0], 1'b0);
            level[0] <= 1'b0;
            wait_clk(8);
            chk(ch_irq[0], k[1]);
            rd(ADDR_CH_CTRL[0], d);
            wr(ADDR_CH_CTRL[0], 8'h00);
        end
    endtask : s_capture
    task automatic s_compare();
        wr(ADDR_CH_CTRL[0], 8'h10);
        wait_clk(2);
        chk(pin_out[0], 1'b0);
        wr(ADDR_CH_HIGH[0], 8'h00);
        wr(ADDR_CH_LOW[0], 8'h03);
        wr(ADDR_CH_CTRL[0], 8'h1C);
        wr(ADDR_TIMER_CTRL, 8'h10);
        wait_clk(12);
        chk(pin_out & pin_oe, 2'h1);
        wr(ADDR_TIMER_CTRL, 8'h30);
        wr(ADDR_CH_CTRL[0], 8'h18);
        wr(ADDR_TIMER_CTRL, 8'h10);
        wait_clk(12);
        chk(pin_out[0], 1'b0);
        wr(ADDR_CH_CTRL[0], 8'h19);
        wait_clk(20);
        chk(pin_out[0], 1'b1);
        wr(ADDR_CH_HIGH[0], 8'h00);
        wr(ADDR_CH_LOW[0], 8'h00);
        wr(ADDR_CH_CTRL[0], 8'h1A);
        d[0] = pin_out[0];
        wait_clk(8);
        chk(pin_out[0], !d[0]);
        wr(ADDR_CH_HIGH[0], 8'h00);
        rd(ADDR_CH_CTRL[0], d);
        wr(ADDR_CH_CTRL[0], 8'h18);
        wait_clk(20);
        rdc(ADDR_CH_CTRL[0], 8'h18);
        wr(ADDR_CH_LOW[0], 8'h00);
        wait_clk(10);
        rdc(ADDR_CH_CTRL[0], 8'h98);
        wr(ADDR_TIMER_CTRL, 8'h30);
        wr(ADDR_CH_CTRL[1], 8'h1C);
        chk(pin_oe[1], 1'b1);
        wr(ADDR_CH_CTRL[0], 8'h2C);
        chk(pin_oe[1], 1'b0);
        wr(ADDR_CH_CTRL[1], 8'h14);
        rdc(ADDR_CH_CTRL[1], 8'h1C);
    endtask : s_compare
    task automatic results();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        s_count();
        s_wrap();
        s_capture();
        s_compare();
        results();
    end
endmodule : test_timer_capture_pwm
bind timer_capture_pwm timer_capture_pwm_asserts chk_i (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .channel_pin_out, .channel_pin_oe_out, .wrap_irq_out, .channel_irq_out);
